// ==== nsw_pkg.sv ====
package nsw_pkg;
	// register offsets on the plain port
	localparam logic [3:0] NSW_A_CTRL = 4'h0;
	localparam logic [3:0] NSW_A_UNLOCK = 4'h1;
	localparam logic [3:0] NSW_A_DATA = 4'h2;
	localparam logic [3:0] NSW_A_LOC = 4'h3;
	localparam logic [3:0] NSW_A_TPL = 4'h4;
	localparam logic [3:0] NSW_A_TPH = 4'h5;
	localparam logic [3:0] NSW_A_TPU = 4'h6;
	localparam logic [3:0] NSW_A_TLAT = 4'h7;
	localparam logic [3:0] NSW_A_FLAGS = 4'h8;
	// control register bit positions
	localparam int NSW_B_RD = 0;
	localparam int NSW_B_WR = 1;
	localparam int NSW_B_WRITE_UNLOCK_ENABLE = 2;
	localparam int NSW_B_WRITE_ABORT_FLAG = 3;
	localparam int NSW_B_FREE = 4;
	localparam int NSW_B_CONFIG_SPACE_SELECT = 6;
	localparam int NSW_B_PGD = 7;
	// done flag position in the second flag register
	localparam int NSW_B_DONE = 4;
	// unlock keys
	localparam logic [7:0] NSW_KEY1 = 8'h55;
	localparam logic [7:0] NSW_KEY2 = 8'hAA;
	// table pointer upper byte implemented bits
	localparam logic [7:0] NSW_TPU_MASK = 8'h3F;
	// self-timed write duration
	localparam int NSW_CLK_MHZ = 100;
	localparam int NSW_WRITE_US = 2000;
	localparam int NSW_WRITE_CYC = NSW_WRITE_US * NSW_CLK_MHZ;
	// memory target of a cycle
	typedef enum logic [1:0] {NSW_SP_EE, NSW_SP_FLASH, NSW_SP_CFG} nsw_space_t;
	// request to the memory array model port
	typedef struct packed {
		logic rd;
		logic wr;
		logic erase;
		nsw_space_t space;
		logic [21:0] addr;
		logic [7:0] data;
	} nsw_mem_req_t;
endpackage

// ==== nsw_timer.sv ====
`timescale 1ns/10ps
// self-timed programming counter: load on start, pulse when it reaches zero
module nsw_timer
	import nsw_pkg::*;
#(
	parameter int CYCLES = NSW_WRITE_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// control
	input wire logic i_start,
	// status
	output logic o_busy,
	output logic o_done
);
	typedef struct packed {
		logic [31:0] cnt;
		logic busy;
		logic done;
	} nsw_tmr_t;
	nsw_tmr_t st_r, st_nxt;

	// count down; done is a one-cycle pulse at expiry
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (i_start && !st_r.busy) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt = 32'(CYCLES - 1);
		end else if (st_r.busy) begin
			if (st_r.cnt == 32'h0) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_busy = st_r.busy;
	assign o_done = st_r.done;
endmodule

// ==== nsw_ctrl.sv ====
`timescale 1ns/10ps
module nsw_ctrl
	import nsw_pkg::*;
#(
	parameter int WRITE_CYCLES = NSW_WRITE_CYC,
	parameter int LOC_W = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// memory array port
	output nsw_mem_req_t o_mem,
	input wire logic [7:0] i_mem_rdata,
	// status
	output logic o_busy,
	output logic o_done_flag
);
	typedef enum logic [1:0] {KS_IDLE, KS_KEY1, KS_ARMED} nsw_key_t;
	typedef struct packed {
		logic pgd;
		logic config_space_select;
		logic free;
		logic write_abort_flag;
		logic write_unlock_enable;
		logic wr;
		logic rd;
		logic [7:0] data;
		logic [LOC_W-1:0] loc;
		logic [21:0] tptr;
		logic [7:0] tlat;
		logic done;
		nsw_key_t key;
		logic [7:0] rdata;
		nsw_mem_req_t mem;
		logic rd_pend;
	} nsw_state_t;

	nsw_state_t st_r, st_nxt;
	logic tmr_busy;
	logic tmr_done;
	logic tmr_start;
	logic [7:0] ctrl_view;
	logic wr_ctrl;
	logic wr_key;
	nsw_space_t space;

	// self-timed programming, so software has no say in cycle length
	nsw_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_start(tmr_start),
		.o_busy(tmr_busy),
		.o_done(tmr_done)
	);

	// target space decode
	always_comb begin
		if (st_r.config_space_select) begin
			space = NSW_SP_CFG;
		end else if (st_r.pgd) begin
			space = NSW_SP_FLASH;
		end else begin
			space = NSW_SP_EE;
		end
	end

	// control register as software sees it; bit 5 is unimplemented
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[NSW_B_PGD] = st_r.pgd;
		ctrl_view[NSW_B_CONFIG_SPACE_SELECT] = st_r.config_space_select;
		ctrl_view[NSW_B_FREE] = st_r.free;
		ctrl_view[NSW_B_WRITE_ABORT_FLAG] = st_r.write_abort_flag;
		ctrl_view[NSW_B_WRITE_UNLOCK_ENABLE] = st_r.write_unlock_enable;
		ctrl_view[NSW_B_WR] = st_r.wr;
		ctrl_view[NSW_B_RD] = st_r.rd;
	end

	assign wr_ctrl = i_wr && (i_addr == NSW_A_CTRL);
	assign wr_key = i_wr && (i_addr == NSW_A_UNLOCK);
	// start the timer only on an accepted write start
	assign tmr_start = st_nxt.wr && !st_r.wr && !tmr_busy;

	// next state of the whole controller
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd = 1'b0;
		st_nxt.mem.rd = 1'b0;
		st_nxt.mem.wr = 1'b0;
		st_nxt.mem.erase = 1'b0;
		st_nxt.rd_pend = 1'b0;
		// capture EEPROM byte the cycle after the read strobe
		if (st_r.rd_pend) begin
			st_nxt.data = i_mem_rdata;
		end
		// key sequence tracker; a write to any register but the control register breaks it
		if (wr_key) begin
			if (i_wdata == NSW_KEY1) begin
				st_nxt.key = KS_KEY1;
			end else if (i_wdata == NSW_KEY2 && st_r.key == KS_KEY1) begin
				st_nxt.key = KS_ARMED;
			end else begin
				st_nxt.key = KS_IDLE;
			end
		end else if (i_wr && !wr_ctrl) begin
			st_nxt.key = KS_IDLE;
		end
		// software writes, locked out while programming runs except the flag register
		if (i_wr && !st_r.wr) begin
			case (i_addr)
				NSW_A_CTRL: begin
					st_nxt.pgd = i_wdata[NSW_B_PGD];
					st_nxt.config_space_select = i_wdata[NSW_B_CONFIG_SPACE_SELECT];
					st_nxt.free = i_wdata[NSW_B_FREE];
					st_nxt.write_unlock_enable = i_wdata[NSW_B_WRITE_UNLOCK_ENABLE];
					// abort flag is hardware owned; it rises with write enable
					if (i_wdata[NSW_B_WRITE_UNLOCK_ENABLE] && !st_r.write_unlock_enable) begin
						st_nxt.write_abort_flag = 1'b1;
					end
					if (i_wdata[NSW_B_WR]) begin
						// previous enable, armed keys, else improper attempt
						if (st_r.write_unlock_enable && st_r.key == KS_ARMED) begin
							st_nxt.wr = 1'b1;
							st_nxt.write_abort_flag = 1'b1;
							st_nxt.mem.wr = !st_r.free;
							st_nxt.mem.erase = st_r.free || (space == NSW_SP_EE);
							st_nxt.mem.space = space;
							st_nxt.mem.data = st_r.data;
							st_nxt.mem.addr = (space == NSW_SP_EE) ?
								22'(st_r.loc) : st_r.tptr;
						end else begin
							st_nxt.write_abort_flag = 1'b1;
						end
					end
					// each start consumes the keys
					if (i_wdata[NSW_B_WR]) begin
						st_nxt.key = KS_IDLE;
					end
					if (i_wdata[NSW_B_RD] && !i_wdata[NSW_B_PGD] && !i_wdata[NSW_B_CONFIG_SPACE_SELECT]
						&& !st_r.pgd && !st_r.config_space_select) begin
						st_nxt.rd = 1'b1;
						st_nxt.rd_pend = 1'b1;
						st_nxt.mem.rd = 1'b1;
						st_nxt.mem.space = NSW_SP_EE;
						st_nxt.mem.addr = 22'(st_r.loc);
					end
				end
				NSW_A_DATA: st_nxt.data = i_wdata;
				NSW_A_LOC: st_nxt.loc = i_wdata[LOC_W-1:0];
				NSW_A_TPL: st_nxt.tptr[7:0] = i_wdata;
				NSW_A_TPH: st_nxt.tptr[15:8] = i_wdata;
				NSW_A_TPU: st_nxt.tptr[21:16] = i_wdata[5:0];
				NSW_A_TLAT: st_nxt.tlat = i_wdata;
				NSW_A_FLAGS: st_nxt.done = i_wdata[NSW_B_DONE];
				default: st_nxt.tlat = st_r.tlat;
			endcase
		end else if (i_wr && i_addr == NSW_A_FLAGS) begin
			st_nxt.done = i_wdata[NSW_B_DONE];
		end
		// completion: set wins over a same-cycle software clear
		if (tmr_done) begin
			st_nxt.wr = 1'b0;
			st_nxt.write_abort_flag = 1'b0;
			st_nxt.done = 1'b1;
			if (st_r.free) begin
				st_nxt.free = 1'b0;
			end
		end
		// read port: data one cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				NSW_A_CTRL: st_nxt.rdata = ctrl_view;
				NSW_A_UNLOCK: st_nxt.rdata = 8'h00;
				NSW_A_DATA: st_nxt.rdata = st_r.data;
				NSW_A_LOC: st_nxt.rdata = 8'(st_r.loc);
				NSW_A_TPL: st_nxt.rdata = st_r.tptr[7:0];
				NSW_A_TPH: st_nxt.rdata = st_r.tptr[15:8];
				NSW_A_TPU: st_nxt.rdata = {2'b00, st_r.tptr[21:16]} & NSW_TPU_MASK;
				NSW_A_TLAT: st_nxt.rdata = st_r.tlat;
				NSW_A_FLAGS: st_nxt.rdata = {3'b000, st_r.done, 4'h0};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// write_abort_flag resets to 1 so a reset during programming leaves it set;
	// select bits are kept out of nothing but reset constants
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_r <= '0;
			st_r.write_unlock_enable <= 1'b0;
			st_r.write_abort_flag <= 1'b1;
			st_r.key <= KS_IDLE;
			st_r.mem.space <= NSW_SP_EE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata = st_r.rdata;
	assign o_mem = st_r.mem;
	assign o_busy = st_r.wr;
	assign o_done_flag = st_r.done;
endmodule

// ==== nsw_ctrl_props.sv ====
`timescale 1ns/10ps
module nsw_ctrl_props
	import nsw_pkg::*;
#(
	parameter int WRITE_CYCLES = NSW_WRITE_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// memory and status
	input wire nsw_mem_req_t o_mem,
	input wire logic [7:0] i_mem_rdata,
	input wire logic o_busy,
	input wire logic o_done_flag
);
	// one domain, so one clocking and one reset for all
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	busy_len_a: assert property ($rose(o_busy) |-> o_busy[*8])
		else $error("programming ended too soon");
	busy_done_a: assert property ($fell(o_busy) |-> o_done_flag)
		else $error("done flag missing at completion");
	start_mem_a: assert property ($rose(o_busy) |-> (o_mem.wr || o_mem.erase))
		else $error("busy without a memory cycle");
	ee_erase_a: assert property (o_mem.wr && o_mem.space == NSW_SP_EE |-> o_mem.erase)
		else $error("byte write without erase");
	rd_space_a: assert property (o_mem.rd |-> o_mem.space == NSW_SP_EE && !o_busy)
		else $error("read outside data space");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
	unlock_zero_a: assert property ($past(i_rd) && $past(i_addr) == NSW_A_UNLOCK
		|-> o_rdata == 8'h00) else $error("unlock port read nonzero");
	ctrl_b5_a: assert property ($past(i_rd) && $past(i_addr) == NSW_A_CTRL |-> !o_rdata[5])
		else $error("control bit 5 set");
	cover property ($rose(o_busy));
	cover property ($fell(o_busy));
	cover property (o_mem.rd);
endmodule

bind nsw_ctrl nsw_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) nsw_ctrl_props_inst (
	.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_mem(o_mem), .i_mem_rdata(i_mem_rdata),
	.o_busy(o_busy), .o_done_flag(o_done_flag));

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import nsw_pkg::*;
	logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, pend = 0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, i_mem_rdata = 8'h00, o_rdata, m, d;
	nsw_mem_req_t o_mem;
	logic o_busy, o_done_flag;
	logic [7:0] qe[$], qm[$];
	nsw_mem_req_t qr[$];
	int qb[$];
	int bcnt = 0;
	int num_errors = 0, samples_checked = 0;
	// short timer keeps the run brief
	localparam int TB_CYC = 20;
	// clock
	always #5 i_clk = ~i_clk;
	nsw_ctrl #(.WRITE_CYCLES(TB_CYC)) nsw_ctrl_inst (.i_clk(i_clk), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_mem(o_mem), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
		.o_done_flag(o_done_flag));
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// expected value and mask are queued for the watcher
	task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] k = 8'hFF);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		qe.push_back(e);
		qm.push_back(k);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task chk(input logic [7:0] g);
		logic [7:0] e, k;
		e = qe.pop_front();
		k = qm.pop_front();
		samples_checked++;
		if ((g & k) !== e) begin
			num_errors++;
			$display("wrong value at %0t: read %h expected %h", $time, g, e);
		end
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge i_clk) begin
		if (pend) chk(o_rdata);
		pend <= i_rd;
	end
	// expected memory request, noted before the write that launches it
	task exm(input logic r, input logic w, input logic e, input nsw_space_t s,
		input logic [21:0] a, input logic [7:0] v);
		qr.push_back({r, w, e, s, a, v});
	endtask
	// data field is stale on a read pulse, so it is not compared there
	task chkm(input nsw_mem_req_t g);
		nsw_mem_req_t e;
		e = '0;
		samples_checked++;
		if (qr.size() == 0) begin
			num_errors++;
			$display("wrong value at %0t: unexpected memory request %h", $time, g);
		end else begin
			e = qr.pop_front();
			if (e.rd) g.data = e.data;
			if (g !== e) begin
				num_errors++;
				$display("wrong value at %0t: memory request %h expected %h", $time, g, e);
			end
		end
	endtask
	// busy length and done flag at the end of a self-timed cycle
	task chkb(input int g, input logic f);
		int e;
		e = -1;
		samples_checked++;
		if (qb.size() != 0) e = qb.pop_front();
		if (g != e || f !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t: busy %0d done %b expected %0d", $time, g, f, e);
		end
	endtask
	// request pulses last one cycle, so each is seen at exactly one edge
	always @(posedge i_clk) begin
		if (o_mem.rd || o_mem.wr || o_mem.erase) chkm(o_mem);
	end
	// a busy period cut by reset is not a completion and is skipped
	always @(posedge i_clk) begin
		if (o_busy) begin
			bcnt <= bcnt + 1;
		end else if (bcnt != 0) begin
			if (!i_reset) chkb(bcnt, o_done_flag);
			bcnt <= 0;
		end
	end
	task go(input logic [7:0] c);
		wr(NSW_A_UNLOCK, NSW_KEY1);
		wr(NSW_A_UNLOCK, NSW_KEY2);
		wr(NSW_A_CTRL, c);
	endtask
	// bounded wait, first edge lets busy land
	task wt;
		@(posedge i_clk);
		repeat (60) if (o_busy) @(posedge i_clk);
	endtask
	// one edge first, so a read still in flight is checked before reset clears it
	task rst;
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
	endtask
	task results;
		// expectations never met count as mismatches
		num_errors += qe.size() + qr.size() + qb.size();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h11E7FF99));
		rst();
		rd(NSW_A_CTRL, 8'h08);
		rd(NSW_A_UNLOCK, 8'h00);
		rd(4'hF, 8'h00);
		wr(NSW_A_TPU, 8'hFF);
		rd(NSW_A_TPU, 8'h3F);
		m = 8'($urandom());
		d = 8'($urandom());
		i_mem_rdata <= m;
		wr(NSW_A_LOC, d);
		exm(1'b1, 1'b0, 1'b0, NSW_SP_EE, 22'(d), 8'h00);
		wr(NSW_A_CTRL, 8'h01);
		rd(NSW_A_DATA, m);
		rd(NSW_A_CTRL, 8'h08);
		i_mem_rdata <= ~m;
		wr(NSW_A_CTRL, 8'h81);
		wr(NSW_A_CTRL, 8'h41);
		rd(NSW_A_DATA, m);
		rd(NSW_A_CTRL, 8'h00, 8'h01);
		wr(NSW_A_CTRL, 8'h84);
		wr(NSW_A_CTRL, 8'h86);
		rd(NSW_A_CTRL, 8'h8C);
		rst();
		go(8'h06);
		rd(NSW_A_CTRL, 8'h08, 8'h0A);
		d = 8'($urandom());
		wr(NSW_A_DATA, d);
		wr(NSW_A_CTRL, 8'h04);
		exm(1'b0, 1'b1, 1'b1, NSW_SP_EE, 22'h000000, d);
		qb.push_back(TB_CYC + 1);
		go(8'h06);
		rd(NSW_A_CTRL, 8'h0E);
		wr(NSW_A_DATA, ~d);
		wr(NSW_A_CTRL, 8'h00);
		wt();
		rd(NSW_A_CTRL, 8'h04);
		rd(NSW_A_DATA, d);
		rd(NSW_A_FLAGS, 8'h10);
		wr(NSW_A_FLAGS, 8'h00);
		rd(NSW_A_FLAGS, 8'h00);
		wr(NSW_A_UNLOCK, NSW_KEY2);
		wr(NSW_A_UNLOCK, NSW_KEY1);
		wr(NSW_A_CTRL, 8'h06);
		rd(NSW_A_CTRL, 8'h0C);
		wr(NSW_A_TPU, 8'h2A);
		wr(NSW_A_TPH, 8'h5C);
		wr(NSW_A_TPL, 8'hC0);
		wr(NSW_A_CTRL, 8'h94);
		exm(1'b0, 1'b0, 1'b1, NSW_SP_FLASH, 22'h2A5CC0, d);
		qb.push_back(TB_CYC + 1);
		go(8'h96);
		wt();
		rd(NSW_A_CTRL, 8'h84);
		wr(NSW_A_UNLOCK, NSW_KEY1);
		wr(NSW_A_UNLOCK, NSW_KEY2);
		wr(NSW_A_TLAT, 8'h5A);
		wr(NSW_A_CTRL, 8'h86);
		rd(NSW_A_CTRL, 8'h8C);
		exm(1'b0, 1'b1, 1'b0, NSW_SP_FLASH, 22'h2A5CC0, d);
		go(8'h86);
		rst();
		rd(NSW_A_CTRL, 8'h08);
		repeat (2) @(posedge i_clk);
		results();
	end
	// watchdog
	initial begin
		#100000;
		num_errors++;
		results();
	end
endmodule
